// File: hw/screen_block_scroll_regs.sv
// screen block start address and line count register bank
//
// Operation
// - scroll command fills the ten registers from block1 low to block4 high
// - old start address stays until high byte write commits new word
// - block1 line count is eight bits, height in lines minus one
// - block2 line count is eight bits, height in lines minus one
// - block3 start is a sixteen bit address split low and high
// - block4 start is a sixteen bit address split low and high
// - every byte here is read/write and resets to zero
// - block4 used only in dual panel; shares block2 attributes
// - single panel: block3 height is the smaller of block1, block2
`timescale 1ns/1ps
`default_nettype none
`include "scroll_regs_consts.svh"

module screen_block_scroll_regs
    import scroll_regs_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int BLOCKS = 4
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wdata_in,
    output var  logic [7:0]        rdata_out,
    output var  logic              rd_valid_out,
    input  wire logic              scroll_cmd_in,
    input  wire logic              param_valid_in,
    input  wire logic [7:0]        param_data_in,
    output var  logic              scroll_busy_out,
    input  wire logic              dual_panel_in,
    input  wire logic [1:0]        block2_attr_in,
    output var  screen_cfg_t       cfg_out
);

    generate
        if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
            $error("screen_block_scroll_regs: ADDR_W must be 5 to 8");
        end
        if (BLOCKS != 4) begin : g_bad_blocks
            $error("screen_block_scroll_regs: BLOCKS must be 4");
        end
        // the command walk must cover every start byte and both counts
        if (`SCROLL_PARAM_COUNT != 2 * BLOCKS + 2) begin : g_bad_span
            $error("screen_block_scroll_regs: scroll span mismatch");
        end
    endgenerate

    // ****************************************************************
    // offset decode
    // ****************************************************************
    function automatic reg_sel_t decode(input logic [7:0] ofs);
        reg_sel_t sel;
        sel.kind  = KIND_NONE;
        sel.block = 2'd0;
        if (ofs == `OFS_BLOCK1_START_LOW) begin
            sel.kind  = KIND_START_LOW;
            sel.block = 2'd0;
        end else if (ofs == `OFS_BLOCK1_START_HIGH) begin
            sel.kind  = KIND_START_HIGH;
            sel.block = 2'd0;
        end else if (ofs == `OFS_BLOCK1_LINE_COUNT) begin
            sel.kind  = KIND_LINES;
            sel.block = 2'd0;
        end else if (ofs == `OFS_BLOCK2_START_LOW) begin
            sel.kind  = KIND_START_LOW;
            sel.block = 2'd1;
        end else if (ofs == `OFS_BLOCK2_START_HIGH) begin
            sel.kind  = KIND_START_HIGH;
            sel.block = 2'd1;
        end else if (ofs == `OFS_BLOCK2_LINE_COUNT) begin
            sel.kind  = KIND_LINES;
            sel.block = 2'd1;
        end else if (ofs == `OFS_BLOCK3_START_LOW) begin
            sel.kind  = KIND_START_LOW;
            sel.block = 2'd2;
        end else if (ofs == `OFS_BLOCK3_START_HIGH) begin
            sel.kind  = KIND_START_HIGH;
            sel.block = 2'd2;
        end else if (ofs == `OFS_BLOCK4_START_LOW) begin
            sel.kind  = KIND_START_LOW;
            sel.block = 2'd3;
        end else if (ofs == `OFS_BLOCK4_START_HIGH) begin
            sel.kind  = KIND_START_HIGH;
            sel.block = 2'd3;
        end
        return sel;
    endfunction : decode

    function automatic logic [7:0] min_lines(input logic [7:0] a,
                                             input logic [7:0] b);
        return (a < b) ? a : b;
    endfunction : min_lines

    // one place joins a start word from its two byte halves
    function automatic logic [15:0] start_pair(input logic [7:0] high,
                                               input logic [7:0] low);
        return {high, low};
    endfunction : start_pair

    // ****************************************************************
    // scroll parameter sequencer
    // ****************************************************************
    reg_write_t seq_wr;

    scroll_param_seq #(
        .PARAM_COUNT (`SCROLL_PARAM_COUNT)
    ) u_seq (
        .clk_sys_in     (clk_sys_in),
        .rst_in         (rst_in),
        .cmd_start_in   (scroll_cmd_in),
        .param_valid_in (param_valid_in),
        .param_data_in  (param_data_in),
        .wr_out         (seq_wr),
        .busy_out       (scroll_busy_out)
    );

    // ****************************************************************
    // write merge
    // ****************************************************************
    // the command path wins a same-cycle clash; the host is expected
    // not to poke these registers while a scroll command is running
    reg_write_t wr;
    reg_sel_t   wr_sel;
    reg_sel_t   rd_sel;
    logic [7:0] host_addr;

    assign host_addr = 8'(addr_in);

    always_comb begin
        if (seq_wr.valid) begin
            wr = seq_wr;
        end else begin
            wr.valid = wr_en_in;
            wr.addr  = host_addr;
            wr.data  = wdata_in;
        end
    end

    assign wr_sel = decode(wr.addr);
    assign rd_sel = decode(host_addr);

    // ****************************************************************
    // start address and line count state
    // ****************************************************************
    logic [7:0]  staged_low [BLOCKS];
    logic [7:0]  next_staged_low [BLOCKS];
    logic [15:0] start_addr [BLOCKS];
    logic [15:0] next_start_addr [BLOCKS];
    logic [7:0]  lines1;
    logic [7:0]  next_lines1;
    logic [7:0]  lines2;
    logic [7:0]  next_lines2;

    always_comb begin
        for (int i = 0; i < BLOCKS; i++) begin
            next_staged_low[i] = staged_low[i];
            next_start_addr[i] = start_addr[i];
        end
        next_lines1 = lines1;
        next_lines2 = lines2;
        if (wr.valid) begin
            case (wr_sel.kind)
                KIND_START_LOW: begin
                    // held aside so fetches keep the old full word
                    next_staged_low[wr_sel.block] = wr.data;
                end
                KIND_START_HIGH: begin
                    // commit pairs the new high with the earlier low
                    next_start_addr[wr_sel.block] = start_pair(wr.data,
                        staged_low[wr_sel.block]);
                end
                KIND_LINES: begin
                    if (wr_sel.block == 2'd0) begin
                        next_lines1 = wr.data;
                    end else begin
                        next_lines2 = wr.data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // state registers
    // ****************************************************************

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            for (int i = 0; i < BLOCKS; i++) begin
                staged_low[i] <= `REG_RESET_BYTE;
                start_addr[i] <= `REG_RESET_WORD;
            end
            lines1 <= `REG_RESET_BYTE;
            lines2 <= `REG_RESET_BYTE;
        end else begin
            for (int i = 0; i < BLOCKS; i++) begin
                staged_low[i] <= next_staged_low[i];
                start_addr[i] <= next_start_addr[i];
            end
            lines1 <= next_lines1;
            lines2 <= next_lines2;
        end
    end

    // ****************************************************************
    // derived screen configuration
    // ****************************************************************
    screen_cfg_t next_cfg;

    always_comb begin
        next_cfg.block1_start  = next_start_addr[0];
        next_cfg.block2_start  = next_start_addr[1];
        next_cfg.block3_start  = next_start_addr[2];
        next_cfg.block4_start  = next_start_addr[3];
        next_cfg.block1_lines  = next_lines1;
        next_cfg.block2_lines  = next_lines2;
        // dual panel fixes the lower halves by frame height, not here
        if (dual_panel_in) begin
            next_cfg.block3_lines = `REG_RESET_BYTE;
        end else begin
            next_cfg.block3_lines =
                min_lines(next_lines1, next_lines2);
        end
        next_cfg.block4_enable = dual_panel_in;
        // no separate attribute field for block4 exists
        if (dual_panel_in) begin
            next_cfg.block4_attr = block2_attr_in;
        end else begin
            next_cfg.block4_attr = 2'b00;
        end
    end

    // ****************************************************************
    // configuration register
    // ****************************************************************

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= next_cfg;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // a read in the cycle of a write returns the value before it
    logic [7:0] next_rdata;
    logic       next_rd_valid;

    always_comb begin
        next_rd_valid = rd_en_in;
        next_rdata    = rdata_out;
        if (rd_en_in) begin
            case (rd_sel.kind)
                KIND_START_LOW: begin
                    // reads back the byte last written, committed or not
                    next_rdata = staged_low[rd_sel.block];
                end
                KIND_START_HIGH: begin
                    next_rdata =
                        start_addr[rd_sel.block][15:`START_HIGH_LSB];
                end
                KIND_LINES: begin
                    if (rd_sel.block == 2'd0) begin
                        next_rdata = lines1;
                    end else begin
                        next_rdata = lines2;
                    end
                end
                default: begin
                    next_rdata = `UNMAPPED_READ_BYTE;
                end
            endcase
        end
    end

    // ****************************************************************
    // read data registers
    // ****************************************************************

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out    <= `REG_RESET_BYTE;
            rd_valid_out <= 1'b0;
        end else begin
            rdata_out    <= next_rdata;
            rd_valid_out <= next_rd_valid;
        end
    end

endmodule : screen_block_scroll_regs
`default_nettype wire

// File: shared/scroll_regs_consts.svh
// offsets, field limits, reset values and counts of the scroll register bank
`ifndef SCROLL_REGS_CONSTS_SVH
`define SCROLL_REGS_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_BLOCK1_START_LOW   8'h0B
`define OFS_BLOCK1_START_HIGH  8'h0C
`define OFS_BLOCK1_LINE_COUNT  8'h0D
`define OFS_BLOCK2_START_LOW   8'h0E
`define OFS_BLOCK2_START_HIGH  8'h0F
`define OFS_BLOCK2_LINE_COUNT  8'h10
`define OFS_BLOCK3_START_LOW   8'h11
`define OFS_BLOCK3_START_HIGH  8'h12
`define OFS_BLOCK4_START_LOW   8'h13
`define OFS_BLOCK4_START_HIGH  8'h14

// ****************************************************************
// scroll command parameter span
// ****************************************************************
`define SCROLL_FIRST_OFS       8'h0B
`define SCROLL_PARAM_COUNT     10

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define START_LOW_MSB          7
`define START_HIGH_LSB         8
`define REG_RESET_BYTE         8'h00
`define REG_RESET_WORD         16'h0000
`define UNMAPPED_READ_BYTE     8'h00

`endif

// File: shared/scroll_regs_pkg.sv
// types shared by the scroll register bank and its parameter sequencer
package scroll_regs_pkg;

    // which part of a screen block a register offset selects
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_START_LOW,
        KIND_START_HIGH,
        KIND_LINES
    } reg_kind_t;

    typedef struct packed {
        reg_kind_t  kind;
        logic [1:0] block;
    } reg_sel_t;

    // one byte write toward the bank
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // committed view used by the display fetch logic
    typedef struct packed {
        logic [15:0] block1_start;
        logic [15:0] block2_start;
        logic [15:0] block3_start;
        logic [15:0] block4_start;
        logic [7:0]  block1_lines;
        logic [7:0]  block2_lines;
        logic [7:0]  block3_lines;
        logic        block4_enable;
        logic [1:0]  block4_attr;
    } screen_cfg_t;

    typedef enum logic {
        SEQ_IDLE,
        SEQ_RUN
    } seq_state_t;

endpackage : scroll_regs_pkg

// File: hw/scroll_param_seq.sv
// sequencer that steers scroll command parameter bytes onto the bank
`timescale 1ns/1ps
`default_nettype none
`include "scroll_regs_consts.svh"

module scroll_param_seq
    import scroll_regs_pkg::*;
#(
    parameter int PARAM_COUNT = `SCROLL_PARAM_COUNT
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       cmd_start_in,
    input  wire logic       param_valid_in,
    input  wire logic [7:0] param_data_in,
    output var  reg_write_t wr_out,
    output var  logic       busy_out
);

    generate
        if (PARAM_COUNT < 1 || PARAM_COUNT > 255) begin : g_bad_count
            $error("scroll_param_seq: PARAM_COUNT out of range");
        end
    endgenerate

    seq_state_t state;
    seq_state_t next_state;
    logic [7:0] index;
    logic [7:0] next_index;

    localparam logic [7:0] LAST_INDEX = 8'(PARAM_COUNT - 1);

    // ****************************************************************
    // parameter byte walk
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_index = index;
        wr_out     = '0;
        case (state)
            SEQ_IDLE: begin
                if (cmd_start_in) begin
                    next_state = SEQ_RUN;
                    next_index = 8'h00;
                end
            end
            SEQ_RUN: begin
                // a fresh command restarts the walk at the first byte
                if (cmd_start_in) begin
                    next_index = 8'h00;
                end else if (param_valid_in) begin
                    wr_out.valid = 1'b1;
                    wr_out.addr  = `SCROLL_FIRST_OFS + index;
                    wr_out.data  = param_data_in;
                    if (index == LAST_INDEX) begin
                        next_state = SEQ_IDLE;
                    end else begin
                        next_index = index + 8'h01;
                    end
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= SEQ_IDLE;
            index <= 8'h00;
        end else begin
            state <= next_state;
            index <= next_index;
        end
    end

    assign busy_out = (state == SEQ_RUN);

endmodule : scroll_param_seq
`default_nettype wire

// File: verification/screen_block_scroll_regs_checker.sv
// port assertions for the scroll register bank
`timescale 1ns/1ps
`default_nettype none
module screen_block_scroll_regs_checker
    import scroll_regs_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int BLOCKS = 4
) (
    input wire logic              clk_sys_in,
    input wire logic              rst_in,
    input wire logic              wr_en_in,
    input wire logic              rd_en_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0]        wdata_in,
    input wire logic [7:0]        rdata_out,
    input wire logic              rd_valid_out,
    input wire logic              scroll_cmd_in,
    input wire logic              param_valid_in,
    input wire logic [7:0]        param_data_in,
    input wire logic              scroll_busy_out,
    input wire logic              dual_panel_in,
    input wire logic [1:0]        block2_attr_in,
    input wire screen_cfg_t       cfg_out
);
    // the sequencer wins a shared cycle, so the host write is lost there
    wire logic host_w = wr_en_in && !(param_valid_in && scroll_busy_out);
    wire logic [7:0] min_l = (cfg_out.block1_lines < cfg_out.block2_lines)
        ? cfg_out.block1_lines : cfg_out.block2_lines;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    property p_rd; rd_en_in |=> rd_valid_out; endproperty
    a_rd: assert property (p_rd)
        else $error("read not answered");
    property p_unm;
        rd_en_in && addr_in == 8'h15 |=> rdata_out == 8'h00;
    endproperty
    a_unm: assert property (p_unm)
        else $error("unmapped read not zero");
    property p_b3hi;
        host_w && addr_in == 8'h12
        |=> cfg_out.block3_start[15:8] == $past(wdata_in);
    endproperty
    a_b3hi: assert property (p_b3hi)
        else $error("block3 high byte not committed");
    property p_b4pair;
        host_w && addr_in == 8'h13 ##1 !wr_en_in && !param_valid_in
        ##1 host_w && addr_in == 8'h14
        |=> cfg_out.block4_start == {$past(wdata_in), $past(wdata_in, 3)};
    endproperty
    a_b4pair: assert property (p_b4pair)
        else $error("block4 start pair wrong");
    property p_hold;
        host_w && addr_in == 8'h11 |=> $stable(cfg_out.block3_start);
    endproperty
    a_hold: assert property (p_hold)
        else $error("low byte changed live start");
    property p_l1;
        host_w && addr_in == 8'h0D
        |=> cfg_out.block1_lines == $past(wdata_in);
    endproperty
    a_l1: assert property (p_l1)
        else $error("block1 lines wrong");
    property p_l2;
        host_w && addr_in == 8'h10
        |-> ##1 cfg_out.block2_lines == $past(wdata_in);
    endproperty
    a_l2: assert property (p_l2)
        else $error("block2 lines wrong");
    property p_l3;
        (!dual_panel_in && $stable(cfg_out.block1_lines)
            && $stable(cfg_out.block2_lines))[*2]
        |-> cfg_out.block3_lines == min_l;
    endproperty
    a_l3: assert property (p_l3)
        else $error("block3 lines not the minimum");
    property p_dual;
        dual_panel_in |=> cfg_out.block4_enable
            && cfg_out.block4_attr == $past(block2_attr_in);
    endproperty
    a_dual: assert property (p_dual)
        else $error("block4 not enabled in dual panel");
    property p_busy; scroll_cmd_in |=> scroll_busy_out; endproperty
    a_busy: assert property (p_busy)
        else $error("scroll command not busy");
    c_scroll: cover property (scroll_cmd_in ##1 scroll_busy_out);
    c_dual: cover property (dual_panel_in ##1 cfg_out.block4_enable);
    c_pair: cover property (p_b4pair);
    c_read: cover property (rd_valid_out);
endmodule : screen_block_scroll_regs_checker
bind screen_block_scroll_regs screen_block_scroll_regs_checker #(
    .ADDR_W(ADDR_W), .BLOCKS(BLOCKS)) chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
    .scroll_cmd_in(scroll_cmd_in), .param_valid_in(param_valid_in),
    .param_data_in(param_data_in), .scroll_busy_out(scroll_busy_out),
    .dual_panel_in(dual_panel_in), .block2_attr_in(block2_attr_in),
    .cfg_out(cfg_out));
`default_nettype wire

// File: verification/host_model.sv
// host processor model: register strobes and scroll command bytes
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rd_valid_in,
    input  wire logic [7:0] rdata_in,
    output var  logic       wr_en_out,
    output var  logic       rd_en_out,
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       scroll_cmd_out,
    output var  logic       param_valid_out,
    output var  logic [7:0] param_data_out
);
    initial begin
        {wr_en_out, rd_en_out, scroll_cmd_out, param_valid_out} = 4'h0;
        {addr_out, wdata_out, param_data_out} = 24'h000000;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk_sys_in);
        {wr_en_out, addr_out, wdata_out} = {1'b1, a, x};
        @(negedge clk_sys_in);
        wr_en_out = 1'b0;
        // released data must not look like a held value
        wdata_out = ~x;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] x,
                      output logic ok);
        @(negedge clk_sys_in);
        {rd_en_out, addr_out} = {1'b1, a};
        @(negedge clk_sys_in);
        ok = rd_valid_in;
        x = rdata_in;
        rd_en_out = 1'b0;
    endtask : rd
    task automatic scroll(input logic [79:0] bytes);
        @(negedge clk_sys_in);
        scroll_cmd_out = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys_in);
            {scroll_cmd_out, param_valid_out} = 2'h1;
            param_data_out = bytes[79 - 8 * i -: 8];
        end
        @(negedge clk_sys_in);
        param_valid_out = 1'b0;
        param_data_out = ~param_data_out;
    endtask : scroll
endmodule : host_model
`default_nettype wire

// File: verification/screen_block_scroll_regs_bench.sv
// self-checking bench of the scroll register bank
`timescale 1ns/1ps
`default_nettype none
module screen_block_scroll_regs_bench import scroll_regs_pkg::*;;
    logic        clk_sys_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        dual       = 1'b0;
    logic [1:0]  attr       = 2'h0;
    logic        wr_en, rd_en, rd_valid, cmd, pvalid, busy, ok;
    logic [7:0]  addr, wdata, rdata, pdata, d;
    logic [31:0] seed       = 32'h00014036;
    logic [15:0] v;
    logic [79:0] bytes;
    logic [7:0]  regs [8'h0B:8'h14];
    logic [15:0] com [1:4];
    screen_cfg_t cfg;
    int          n_errors   = 0;
    int          tests_run  = 0;
    int          b;
    always #2.5 clk_sys_in = ~clk_sys_in;
    screen_block_scroll_regs dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .rd_valid_out(rd_valid), .scroll_cmd_in(cmd),
        .param_valid_in(pvalid), .param_data_in(pdata),
        .scroll_busy_out(busy), .dual_panel_in(dual),
        .block2_attr_in(attr), .cfg_out(cfg));
    host_model host (
        .clk_sys_in(clk_sys_in), .rd_valid_in(rd_valid), .rdata_in(rdata),
        .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
        .wdata_out(wdata), .scroll_cmd_out(cmd), .param_valid_out(pvalid),
        .param_data_out(pdata));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [7:0] low_ofs(input int k);
        return (k == 4) ? 8'h13 : 8'h0B + 8'(3 * k - 3);
    endfunction : low_ofs
    function automatic logic [15:0] got_start(input int k);
        return k == 1 ? cfg.block1_start : k == 2 ? cfg.block2_start
             : k == 3 ? cfg.block3_start : cfg.block4_start;
    endfunction : got_start
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    // low bytes only stage; a high byte commits the staged pair
    task automatic model(input logic [7:0] a, input logic [7:0] x);
        regs[a] = x;
        for (int k = 1; k <= 4; k++)
            if (a == low_ofs(k) + 8'h01) com[k] = {x, regs[a - 8'h01]};
    endtask : model
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        host.wr(a, x);
        model(a, x);
    endtask : wr
    task automatic rd_all();
        for (int a = 8'h0B; a <= 8'h15; a++) begin
            host.rd(8'(a), d, ok);
            check({7'h00, ok, d},
                {8'h01, a < 8'h15 ? regs[a] : 8'h00});
        end
    endtask : rd_all
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
    initial begin
        for (int a = 8'h0B; a <= 8'h14; a++) regs[a] = 8'h00;
        for (int k = 1; k <= 4; k++) com[k] = 16'h0000;
        repeat (6) @(posedge clk_sys_in);
        @(negedge clk_sys_in) rst_in = 1'b0;
        rd_all();
        for (int i = 0; i < 12; i++) begin
            b = i % 4 + 1;
            v = 16'(rnd());
            wr(low_ofs(b), v[7:0]);
            check(got_start(b), com[b]);
            wr(low_ofs(b) + 8'h01, v[15:8]);
            check(got_start(b), v);
        end
        rd_all();
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 16'h00FF : 16'(rnd());
            // first two passes pin single then dual panel
            {dual, attr} = (i < 2) ? {i[0], 2'b10} : 3'(rnd());
            wr(8'h0D, v[7:0]);
            wr(8'h10, v[15:8]);
            repeat (2) @(negedge clk_sys_in);
            check({cfg.block2_lines, cfg.block1_lines}, v);
            check({8'h00, cfg.block3_lines}, dual ? 16'h0000 : {8'h00,
                v[7:0] < v[15:8] ? v[7:0] : v[15:8]});
            check({13'h0000, cfg.block4_enable, cfg.block4_attr},
                dual ? {14'h0001, attr} : 16'h0000);
        end
        bytes = {rnd(), rnd(), 16'(rnd())};
        host.scroll(bytes);
        for (int k = 0; k < 10; k++)
            model(8'h0B + 8'(k), bytes[79 - 8 * k -: 8]);
        check({15'h0000, busy}, 16'h0000);
        for (int k = 1; k <= 4; k++) check(got_start(k), com[k]);
        rd_all();
        give_verdict();
    end
endmodule : screen_block_scroll_regs_bench
`default_nettype wire
